// ==== shared/cqr_pkg.sv ====
// constants and carrier types for the configuration query responder
package cqr_pkg;

   // port number field width (port minus one)
   localparam int PORT_W = 7;

   // message codes carried in byte 0
   localparam logic [7:0] CODE_PQUERY = 8'h08;
   localparam logic [7:0] CODE_PREPLY = 8'h09;
   localparam logic [7:0] CODE_RQUERY = 8'h10;
   // arbitrary values for message formats kept outside this block
   localparam logic [7:0] CODE_DREADY = 8'hF1;
   localparam logic [7:0] CODE_DREPLY = 8'hF2;
   localparam logic [7:0] CODE_RESP = 8'hF3;
   localparam logic [7:0] RC_INVALID_FIELD = 8'h01;

   // query layout and reply lengths in bytes
   localparam logic [3:0] QUERY_LAST = 4'h7;
   localparam logic [3:0] LIST_BASE = 4'h4;
   localparam logic [3:0] CNT_BASE = 4'h4;
   localparam logic [3:0] PREPLY_LEN = 4'hF;
   localparam logic [3:0] RESP_LEN = 4'h4;
   localparam logic [3:0] DREADY_LEN = 4'hC;

   // table record layout
   localparam logic [31:0] REC_BYTES = 32'h0000_0012;
   localparam int REC_WORDS = 5;
   localparam logic [2:0] STAT_WORD = 3'h4;
   localparam logic [3:0] FRAME_RECS_LAST = 4'h7;
   localparam int LIVE_BIT = 8;

   // register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_LIST0 = 12'h008;
   localparam logic [11:0] ADDR_LIST1 = 12'h00C;
   localparam logic [11:0] ADDR_LIST2 = 12'h010;
   localparam logic [11:0] ADDR_TCOUNT = 12'h014;
   localparam logic [11:0] ADDR_TABLE = 12'h100;
   localparam int CTRL_EN_BIT = 0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR = 3'b001,
      ST_WAIT = 3'b010,
      ST_FETCH = 3'b011,
      ST_LOAD = 3'b100,
      ST_EMIT = 3'b101
   } cqr_state_e;

   typedef enum logic [1:0] {
      KIND_PREPLY = 2'b00,
      KIND_RESP = 2'b01,
      KIND_DREADY = 2'b10,
      KIND_DATA = 2'b11
   } cqr_kind_e;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
      logic [PORT_W-1:0] port;
   } cqr_rx_s;

   typedef struct packed {
      logic [7:0] code;
      logic [15:0] tag;
      logic [31:0] path;
      logic [PORT_W-1:0] port;
      logic len_ok;
   } cqr_hdr_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
      cqr_kind_e kind;
      logic [15:0] tag;
      logic [31:0] path;
      logic [PORT_W-1:0] port;
   } cqr_tx_s;

endpackage

// ==== hdl/cqr_table_mem.sv ====
// configurator table word memory, registered read
`timescale 1ns/10ps
`default_nettype none
module cqr_table_mem #(
   parameter int DEPTH = 80,
   parameter int AW = 7
) (
   // clock and enable
   input wire logic clk,
   input wire logic ce,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [31:0] wr_data,
   // read port
   input wire logic [AW-1:0] rd_addr,
   output logic [31:0] rd_data
);
   logic [31:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

// ==== hdl/cqr_rx_parser.sv ====
// collects the header bytes of an incoming service message
`timescale 1ns/10ps
`default_nettype none
module cqr_rx_parser (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // byte stream in
   input wire cqr_pkg::cqr_rx_s rx,
   // parsed header
   output cqr_pkg::cqr_hdr_s hdr,
   output logic hdr_valid
);
   typedef struct packed {
      logic [3:0] cnt;
      cqr_pkg::cqr_hdr_s hdr;
      logic valid;
   } cqr_prs_s;

   cqr_prs_s q;
   cqr_prs_s d;

   always_comb begin
      d = q;
      d.valid = 1'b0;
      if (rx.valid) begin
         if (q.cnt == 4'h0) begin
            d.hdr.code = rx.data;
            d.hdr.port = rx.port;
         end else if (q.cnt == 4'h2 || q.cnt == 4'h3) begin
            d.hdr.tag = {q.hdr.tag[7:0], rx.data};
         end else if (q.cnt >= cqr_pkg::LIST_BASE && q.cnt <= cqr_pkg::QUERY_LAST) begin
            d.hdr.path = {q.hdr.path[23:0], rx.data};
         end
         // RQ19 reserved byte ignored
         if (q.cnt != 4'hF) begin
            d.cnt = q.cnt + 4'h1;
         end
         if (rx.last) begin
            d.valid = 1'b1;
            d.hdr.len_ok = (q.cnt == cqr_pkg::QUERY_LAST);
            d.cnt = 4'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign hdr = q.hdr;
   assign hdr_valid = q.valid;
endmodule
`default_nettype wire

// ==== hdl/cqr_config_query_responder.sv ====
// configuration query responder: protocol and registration queries
// Operation
// RQ1: protocol query is 08h, reserved, two-byte tag, four-byte return path
// RQ2: an invalid protocol query gets a response with invalid-field code
// RQ3: requester keeps every outstanding tag distinct
// RQ4: reply carries the query return path as its address path
// RQ5: protocol reply leaves on the port the query came in on
// RQ6: protocol reply is 09h, reserved zero, then the query tag
// RQ7: protocol list is 11 bytes from byte 4, packed, zero padded
// RQ8: each standard protocol is one code byte in the list
// RQ9: vendor protocol is a code byte plus four-byte identifier
// RQ10: every listed protocol code is distinct
// RQ11: registration query is 10h, reserved, tag, return path
// RQ12: tag and return path of registration query reused in answers
// RQ13: data-ready gives total table bytes and a zero byte offset
// RQ14: table data only after the matching data-reply arrives
// RQ15: one 18-byte record per entry, at most 8 per frame
// RQ16: record is handle, path, unique id, status byte, reserved
// RQ17: quiesced but held entry has its status flag clear
// RQ18: live entry has flag set, port is field plus one
// RQ19: reserved output bits are zero, reserved input bits ignored
`timescale 1ns/10ps
`default_nettype none
module cqr_config_query_responder #(
   parameter int MAX_ENTRIES = 16
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // message receive
   input wire cqr_pkg::cqr_rx_s rx,
   // message transmit
   input wire logic tx_ready,
   output cqr_pkg::cqr_tx_s tx
);
   localparam int DEPTH = MAX_ENTRIES * cqr_pkg::REC_WORDS;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      cqr_pkg::cqr_state_e st;
      logic [3:0] idx;
      logic [7:0] rec;
      logic [3:0] rif;
      logic [2:0] word;
      logic [1:0] bsel;
      logic [31:0] wq;
      cqr_pkg::cqr_tx_s tx;
      logic en;
      logic [95:0] list;
      logic [7:0] tcount;
      logic [7:0] n_proto;
      logic [7:0] n_bad;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cqr_core_s;

   localparam cqr_core_s CORE_RST = '0;

   cqr_core_s q;
   cqr_core_s d;
   cqr_pkg::cqr_hdr_s ph;
   logic ph_valid;
   logic [31:0] rd_data;
   logic [AW-1:0] rd_addr;
   logic [9:0] tab_idx;
   logic tab_hit;
   logic bus_wr;
   logic tab_wr;

   // header length per reply kind
   function automatic logic [3:0] hdr_len(input cqr_pkg::cqr_kind_e k);
      if (k == cqr_pkg::KIND_PREPLY) begin
         return cqr_pkg::PREPLY_LEN;
      end else if (k == cqr_pkg::KIND_DREADY) begin
         return cqr_pkg::DREADY_LEN;
      end else begin
         return cqr_pkg::RESP_LEN;
      end
   endfunction

   // header byte per reply kind and index
   function automatic logic [7:0] hdr_byte(
      input cqr_pkg::cqr_kind_e k,
      input logic [3:0] i,
      input logic [15:0] tg,
      input logic [95:0] lst,
      input logic [31:0] bc
   );
      logic [95:0] ls;
      logic [31:0] bs;
      logic [7:0] b;
      ls = lst << {i - cqr_pkg::LIST_BASE, 3'b000};
      bs = bc << {i - cqr_pkg::CNT_BASE, 3'b000};
      b = 8'h00;
      if (i == 4'h2) begin
         b = tg[15:8];
      end else if (i == 4'h3) begin
         b = tg[7:0];
      end else if (k == cqr_pkg::KIND_PREPLY) begin
         // RQ6 reply code
         if (i == 4'h0) begin
            b = cqr_pkg::CODE_PREPLY;
         end else if (i >= cqr_pkg::LIST_BASE) begin
            // RQ7 list bytes
            b = ls[95:88];
         end
      end else if (k == cqr_pkg::KIND_RESP) begin
         if (i == 4'h0) begin
            b = cqr_pkg::CODE_RESP;
         end else begin
            b = cqr_pkg::RC_INVALID_FIELD;
         end
      end else begin
         // RQ13 count then zero offset
         if (i == 4'h0) begin
            b = cqr_pkg::CODE_DREADY;
         end else if (i >= cqr_pkg::CNT_BASE && i < cqr_pkg::CNT_BASE + 4'h4) begin
            b = bs[31:24];
         end
      end
      return b;
   endfunction

   cqr_rx_parser u_parser (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .rx(rx),
      .hdr(ph),
      .hdr_valid(ph_valid)
   );

   cqr_table_mem #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_table (
      .clk(clk),
      .ce(ce),
      .wr_en(tab_wr),
      .wr_addr(AW'(tab_idx)),
      .wr_data(pwdata),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // table window decode
   assign tab_idx = paddr[11:2] - cqr_pkg::ADDR_TABLE[11:2];
   assign tab_hit = (paddr >= cqr_pkg::ADDR_TABLE) && (32'(tab_idx) < DEPTH);
   assign bus_wr = psel && penable && q.pready && pwrite;
   assign tab_wr = bus_wr && tab_hit;
   assign rd_addr = AW'(32'(q.rec) * cqr_pkg::REC_WORDS + 32'(q.word));

   always_comb begin
      logic tx_free;
      logic stw;
      logic lastw;
      logic lastt;
      tx_free = !q.tx.valid || tx_ready;
      stw = (q.word == cqr_pkg::STAT_WORD);
      lastw = stw ? (q.bsel == 2'h1) : (q.bsel == 2'h3);
      lastt = (q.rec == q.tcount - 8'h01);
      d = q;

      // apb: zero wait, answer in first access cycle
      d.pready = psel && !penable;
      d.pslverr = 1'b0;
      if (psel && !penable) begin
         d.prdata = '0;
         if (paddr == cqr_pkg::ADDR_CTRL) begin
            d.prdata[cqr_pkg::CTRL_EN_BIT] = q.en;
         end else if (paddr == cqr_pkg::ADDR_STAT) begin
            d.prdata = {8'h00, q.n_bad, q.n_proto, 5'h00, q.st};
         end else if (paddr == cqr_pkg::ADDR_LIST0) begin
            d.prdata = q.list[95:64];
         end else if (paddr == cqr_pkg::ADDR_LIST1) begin
            d.prdata = q.list[63:32];
         end else if (paddr == cqr_pkg::ADDR_LIST2) begin
            d.prdata = q.list[31:0];
         end else if (paddr == cqr_pkg::ADDR_TCOUNT) begin
            d.prdata = {24'h00_0000, q.tcount};
         end else if (!tab_hit) begin
            d.pslverr = 1'b1;
         end
      end
      if (bus_wr) begin
         if (paddr == cqr_pkg::ADDR_CTRL) begin
            d.en = pwdata[cqr_pkg::CTRL_EN_BIT];
         end else if (paddr == cqr_pkg::ADDR_LIST0) begin
            // RQ8 software packs codes
            d.list[95:64] = pwdata;
         end else if (paddr == cqr_pkg::ADDR_LIST1) begin
            // RQ9 vendor entries packed
            d.list[63:32] = pwdata;
         end else if (paddr == cqr_pkg::ADDR_LIST2) begin
            // RQ10 RQ19 list tail, pad zero
            d.list[31:0] = {pwdata[31:8], 8'h00};
         end else if (paddr == cqr_pkg::ADDR_TCOUNT) begin
            if (pwdata[7:0] > 8'(MAX_ENTRIES)) begin
               d.tcount = 8'(MAX_ENTRIES);
            end else begin
               d.tcount = pwdata[7:0];
            end
         end
      end

      // transmit handshake
      if (q.tx.valid && tx_ready) begin
         d.tx.valid = 1'b0;
      end

      case (q.st)
         cqr_pkg::ST_IDLE: begin
            if (ph_valid && q.en && !q.tx.valid) begin
               if (ph.code == cqr_pkg::CODE_PQUERY || ph.code == cqr_pkg::CODE_RQUERY) begin
                  // RQ4 RQ5 RQ12 keep path, port, tag
                  d.tx.tag = ph.tag;
                  d.tx.path = ph.path;
                  d.tx.port = ph.port;
                  d.idx = 4'h0;
                  d.st = cqr_pkg::ST_HDR;
                  // RQ2 invalid field answer
                  if (!ph.len_ok) begin
                     d.tx.kind = cqr_pkg::KIND_RESP;
                     d.n_bad = q.n_bad + 8'h01;
                  end else if (ph.code == cqr_pkg::CODE_PQUERY) begin
                     d.tx.kind = cqr_pkg::KIND_PREPLY;
                     d.n_proto = q.n_proto + 8'h01;
                  end else begin
                     d.tx.kind = cqr_pkg::KIND_DREADY;
                  end
               end
            end
         end
         cqr_pkg::ST_HDR: begin
            if (tx_free) begin
               d.tx.valid = 1'b1;
               d.tx.data = hdr_byte(q.tx.kind, q.idx, q.tx.tag, q.list,
                                    32'(q.tcount) * cqr_pkg::REC_BYTES);
               d.tx.last = (q.idx == hdr_len(q.tx.kind) - 4'h1);
               d.idx = q.idx + 4'h1;
               if (d.tx.last) begin
                  if (q.tx.kind == cqr_pkg::KIND_DREADY) begin
                     d.st = cqr_pkg::ST_WAIT;
                  end else begin
                     d.st = cqr_pkg::ST_IDLE;
                  end
               end
            end
         end
         cqr_pkg::ST_WAIT: begin
            if (!q.en) begin
               d.st = cqr_pkg::ST_IDLE;
            end else if (ph_valid && ph.code == cqr_pkg::CODE_DREPLY && ph.tag == q.tx.tag
                         && !q.tx.valid) begin
               // RQ14 data only after data-reply
               if (q.tcount == 8'h00) begin
                  d.st = cqr_pkg::ST_IDLE;
               end else begin
                  d.rec = 8'h00;
                  d.rif = 4'h0;
                  d.word = 3'h0;
                  d.tx.kind = cqr_pkg::KIND_DATA;
                  d.st = cqr_pkg::ST_FETCH;
               end
            end
         end
         cqr_pkg::ST_FETCH: begin
            d.st = cqr_pkg::ST_LOAD;
         end
         cqr_pkg::ST_LOAD: begin
            d.wq = rd_data;
            d.bsel = 2'h0;
            d.st = cqr_pkg::ST_EMIT;
         end
         cqr_pkg::ST_EMIT: begin
            if (tx_free) begin
               d.tx.valid = 1'b1;
               if (stw) begin
                  // RQ16 RQ17 RQ18 status byte
                  if (q.bsel == 2'h0) begin
                     d.tx.data = {q.wq[cqr_pkg::LIVE_BIT], q.wq[cqr_pkg::PORT_W-1:0]};
                  end else begin
                     d.tx.data = 8'h00;
                  end
               end else begin
                  // RQ16 big-endian words
                  d.tx.data = q.wq[31:24];
               end
               d.wq = {q.wq[23:0], 8'h00};
               // RQ15 frame ends after 8 records or after the last table record
               d.tx.last = stw && lastw && (lastt || q.rif == cqr_pkg::FRAME_RECS_LAST);
               if (!lastw) begin
                  d.bsel = q.bsel + 2'h1;
               end else if (!stw) begin
                  d.word = q.word + 3'h1;
                  d.st = cqr_pkg::ST_FETCH;
               end else if (lastt) begin
                  d.st = cqr_pkg::ST_IDLE;
               end else begin
                  d.rec = q.rec + 8'h01;
                  d.word = 3'h0;
                  if (q.rif == cqr_pkg::FRAME_RECS_LAST) begin
                     d.rif = 4'h0;
                  end else begin
                     d.rif = q.rif + 4'h1;
                  end
                  d.st = cqr_pkg::ST_FETCH;
               end
            end
         end
         default: begin
            d.st = cqr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= CORE_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign tx = q.tx;
endmodule
`default_nettype wire

// ==== tb/cqr_partner.sv ====
// configurator node model: sends service messages, takes replies with stalls
`timescale 1ns/10ps
`default_nettype none
module cqr_partner (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // towards the responder
   output cqr_pkg::cqr_rx_s rx,
   output logic tx_ready,
   // from the responder
   input wire cqr_pkg::cqr_tx_s tx
);
   int seed = 34318;
   initial begin
      rx = '0;
      tx_ready = 1'h0;
   end
   // sink with random stalls
   always @(posedge clk) begin
      tx_ready <= rst_n && ($random(seed) % 4 != 0);
   end
   task automatic send(input logic [63:0] m, input int n, input logic [6:0] p);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx.valid <= 1'h1;
         rx.data <= m[63-8*i -: 8];
         rx.last <= (i == n - 1);
         rx.port <= p;
      end
      @(posedge clk);
      rx.valid <= 1'h0;
      rx.last <= 1'h0;
      rx.data <= ~rx.data;
      rx.port <= ~p;
   endtask
endmodule
`default_nettype wire

// ==== tb/cqr_config_query_responder_sva.sv ====
// assertion checker for the configuration query responder
`timescale 1ns/10ps
`default_nettype none
module cqr_config_query_responder_sva (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // messages
   input wire cqr_pkg::cqr_rx_s rx,
   input wire logic tx_ready,
   input wire cqr_pkg::cqr_tx_s tx
);
   logic [7:0] idx_q;
   logic [4:0] rb_q;
   logic [3:0] nrec_q;
   logic acc;
   assign acc = tx.valid && tx_ready;
   // byte, record and per-frame record counters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= 8'h00;
         rb_q <= 5'h00;
         nrec_q <= 4'h0;
      end else if (acc) begin
         idx_q <= tx.last ? 8'h00 : idx_q + 8'h01;
         if (tx.kind == cqr_pkg::KIND_DATA) begin
            rb_q <= (rb_q == 5'h11) ? 5'h00 : rb_q + 5'h01;
            if (rb_q == 5'h11) begin
               nrec_q <= tx.last ? 4'h0 : nrec_q + 4'h1;
            end
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_apb_rdy; psel && penable |-> pready; endproperty
   a_apb_rdy: assert property (p_apb_rdy) else $error("pready missing");
   property p_unmap;
      psel && penable && paddr == 12'h020 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
   property p_hold; tx.valid && !tx_ready |=> tx.valid && $stable(tx); endproperty
   a_hold: assert property (p_hold) else $error("tx changed before accept");
   property p_code;
      tx.valid && idx_q == 8'h00 && tx.kind == cqr_pkg::KIND_PREPLY |-> tx.data == 8'h09;
   endproperty
   a_code: assert property (p_code) else $error("reply code wrong");
   property p_rsvd;
      tx.valid && idx_q == 8'h01 && tx.kind inside {cqr_pkg::KIND_PREPLY, cqr_pkg::KIND_DREADY}
         |-> tx.data == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
   property p_tag;
      tx.valid && tx.kind != cqr_pkg::KIND_DATA && idx_q inside {8'h02, 8'h03}
         |-> tx.data == (idx_q == 8'h02 ? tx.tag[15:8] : tx.tag[7:0]);
   endproperty
   a_tag: assert property (p_tag) else $error("tag bytes wrong");
   property p_plen; tx.valid && tx.last && tx.kind == cqr_pkg::KIND_PREPLY |-> idx_q == 8'h0E;
   endproperty
   a_plen: assert property (p_plen) else $error("reply length wrong");
   property p_rlen;
      tx.valid && tx.kind == cqr_pkg::KIND_RESP |-> idx_q < 8'h04 && tx.last == (idx_q == 8'h03);
   endproperty
   a_rlen: assert property (p_rlen) else $error("response length wrong");
   property p_dzero;
      tx.valid && tx.kind == cqr_pkg::KIND_DREADY && idx_q >= 8'h08
         |-> tx.data == 8'h00 && idx_q <= 8'h0B;
   endproperty
   a_dzero: assert property (p_dzero) else $error("byte offset not zero");
   property p_rec;
      acc && tx.last && tx.kind == cqr_pkg::KIND_DATA |-> rb_q == 5'h11 && nrec_q <= 4'h7;
   endproperty
   a_rec: assert property (p_rec) else $error("data frame records wrong");
   property p_r17; tx.valid && tx.kind == cqr_pkg::KIND_DATA && rb_q == 5'h11 |-> tx.data == 8'h00;
   endproperty
   a_r17: assert property (p_r17) else $error("record byte 17 not zero");
endmodule
bind cqr_config_query_responder cqr_config_query_responder_sva u_sva (.clk(clk), .rst_n(rst_n),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx), .tx_ready(tx_ready), .tx(tx));
`default_nettype wire

// ==== tb/cqr_config_query_responder_tb.sv ====
// self-checking bench for the configuration query responder
`timescale 1ns/10ps
`default_nettype none
module cqr_config_query_responder_tb;
   logic clk;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   cqr_pkg::cqr_rx_s rx;
   cqr_pkg::cqr_tx_s tx;
   logic tx_ready;
   int err_total = 0;
   int checks = 0;
   int seed = 34318;
   logic [65:0] tq [$];
   logic [32:0] aq [$];
   logic [65:0] e;
   logic [65:0] got;
   logic [32:0] ea;
   logic [32:0] ga;
   cqr_pkg::cqr_kind_e k_c;
   logic [6:0] p_c;
   logic [31:0] a_c;
   logic [31:0] pm = 32'h0000_0000;
   logic [15:0] t_c = 16'h0000;
   logic [7:0] lst [11];
   logic [31:0] tw [45];
   cqr_config_query_responder dut (.clk(clk), .rst_n(rst_n), .ce(1'h1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx(rx), .tx_ready(tx_ready), .tx(tx));
   cqr_partner part (.clk(clk), .rst_n(rst_n), .rx(rx), .tx_ready(tx_ready), .tx(tx));
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   task automatic end_sim;
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      end_sim();
   end
   // result watcher against the noted expectations
   always @(posedge clk) begin
      if (tx.valid === 1'h1 && tx_ready === 1'h1) begin
         got = {tx.kind, tx.port, tx.path, tx.tag, tx.last, tx.data};
         e = 'x;
         if (tq.size() != 0) e = tq.pop_front();
         checks++;
         if (got !== e) begin
            err_total++;
            $display("wrong value tx expected %h seen %h", e, got);
         end
      end
      if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
         ea = 'x;
         if (aq.size() != 0) ea = aq.pop_front();
         ga = {pslverr, pwrite ? ea[31:0] : prdata};
         checks++;
         if (ga !== ea) begin
            err_total++;
            $display("wrong value apb expected %h seen %h", ea, ga);
         end
      end
   end
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
         input logic [32:0] ex);
      aq.push_back(ex);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic put(input logic [7:0] d, input logic l);
      tq.push_back({k_c, p_c, pm, t_c, l, d});
   endtask
   task automatic drain;
      for (int n = 0; n < 3000 && tq.size() != 0; n++) @(posedge clk);
      repeat (20) @(posedge clk);
   endtask
   task automatic query(input logic [7:0] c, input int n, input logic ok);
      logic [31:0] bc;
      logic pq;
      bc = 32'h0000_00A2;
      pq = (c == cqr_pkg::CODE_PQUERY);
      t_c = t_c + 16'h0001;
      p_c = 7'($random(seed));
      a_c = $random(seed);
      // short query shifts only part of the path into the held one
      pm = 32'({pm, a_c} >> (8 * (8 - n)));
      if (ok && n != 8) begin
         k_c = cqr_pkg::KIND_RESP;
         put(cqr_pkg::CODE_RESP, 1'h0);
         put(cqr_pkg::RC_INVALID_FIELD, 1'h0);
      end else if (ok) begin
         k_c = pq ? cqr_pkg::KIND_PREPLY : cqr_pkg::KIND_DREADY;
         put(pq ? cqr_pkg::CODE_PREPLY : cqr_pkg::CODE_DREADY, 1'h0);
         put(8'h00, 1'h0);
      end
      if (ok) put(t_c[15:8], 1'h0);
      if (ok) put(t_c[7:0], n != 8);
      for (int i = 0; ok && n == 8 && i < (pq ? 11 : 8); i++) begin
         put(pq ? lst[i] : (i < 4 ? bc[31-8*i -: 8] : 8'h00), pq ? i == 10 : i == 7);
      end
      part.send({c, 8'($random(seed)), t_c, a_c}, n, p_c);
      drain();
   endtask
   task automatic table_out;
      for (int r = 0; r < 9; r++) begin
         for (int i = 0; i < 16; i++) put(tw[5*r+i/4][31-8*(i%4) -: 8], 1'h0);
         put({tw[5*r+4][8], tw[5*r+4][6:0]}, 1'h0);
         put(8'h00, r == 7 || r == 8);
      end
   endtask
   initial begin
      lst = '{8'h01, 8'h80, 8'h5A, 8'h3C, 8'h11, 8'h22, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
      rst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      apb(1'h0, cqr_pkg::ADDR_CTRL, 32'h0, 33'h0);
      apb(1'h0, cqr_pkg::ADDR_STAT, 32'h0, 33'h0);
      query(cqr_pkg::CODE_PQUERY, 8, 1'h0);
      apb(1'h1, cqr_pkg::ADDR_LIST0, {lst[0], lst[1], lst[2], lst[3]}, 33'h0);
      apb(1'h1, cqr_pkg::ADDR_LIST1, {lst[4], lst[5], lst[6], lst[7]}, 33'h0);
      apb(1'h1, cqr_pkg::ADDR_LIST2, {lst[8], lst[9], lst[10], 8'hFF}, 33'h0);
      apb(1'h0, cqr_pkg::ADDR_LIST2, 32'h0, 33'h0);
      apb(1'h1, cqr_pkg::ADDR_CTRL, 32'h1, 33'h0);
      apb(1'h0, 12'h020, 32'h0, 33'h1_0000_0000);
      apb(1'h0, cqr_pkg::ADDR_TABLE, 32'h0, 33'h0);
      repeat (3) query(cqr_pkg::CODE_PQUERY, 8, 1'h1);
      query(cqr_pkg::CODE_PQUERY, 7, 1'h1);
      query(cqr_pkg::CODE_RQUERY, 5, 1'h1);
      apb(1'h0, cqr_pkg::ADDR_STAT, 32'h0, 33'h0_0002_0300);
      for (int w = 0; w < 45; w++) begin
         tw[w] = $random(seed);
         if (w % 5 == 4) tw[w][8] = 1'((w / 5) % 2);
         apb(1'h1, cqr_pkg::ADDR_TABLE + 12'(4 * w), tw[w], 33'h0);
      end
      apb(1'h1, cqr_pkg::ADDR_TCOUNT, 32'h9, 33'h0);
      apb(1'h0, cqr_pkg::ADDR_TCOUNT, 32'h0, 33'h0_0000_0009);
      query(cqr_pkg::CODE_RQUERY, 8, 1'h1);
      part.send({cqr_pkg::CODE_DREPLY, 8'h00, ~t_c, a_c}, 8, p_c);
      drain();
      k_c = cqr_pkg::KIND_DATA;
      table_out();
      part.send({cqr_pkg::CODE_DREPLY, 8'h00, t_c, a_c}, 8, p_c);
      drain();
      if (tq.size() != 0 || aq.size() != 0) begin
         err_total++;
         $display("wrong value queue expected 0 seen %0d", tq.size() + aq.size());
      end
      end_sim();
   end
endmodule
`default_nettype wire
